// file: core/duhp_pkg.sv
// constants, types and carriers for the dual channel host bus port
// Function
// - three address lines pick the register
// - eight-bit two-way data bus
// - read strobe fall reads, host samples rise
// - write strobe fall starts, rise latches data
// - read strobe ignored in single-line style
// - single-line style: direction line, high reads
// - separate style: one select per channel
// - single-line style: channel A select is chip select
// - single-line style: channel B select picks channel
// - separate style: channel A high interrupt
// - separate style: channel B high interrupt
// - separate style: interrupt driven only when enabled
// - single-line style: shared low open-drain interrupt
// - single-line style: channel B interrupt unused
// - four power modes, active after power-up
// - each mode entered by pin or register
// - partial stops one source, full stops both
// - power-save isolates bus while sleeping
// - serial receivers stay enabled in every mode
// - wake-up interrupt on leaving low power
package duhp_pkg;

    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int NUM_REGS = 8;
    localparam int NUM_CHAN = 2;

    localparam logic [2:0] IIR_IDX = 3'h2;
    localparam logic [2:0] MCR_IDX = 3'h4;
    localparam logic [2:0] PWR_IDX = 3'h7;

    localparam int MCR_OE_BIT = 3;
    localparam int PWR_OSC_BIT = 0;
    localparam int PWR_PUMP_BIT = 1;
    localparam int PWR_SAVE_BIT = 2;

    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] DOUT_RST = 8'h00;
    localparam logic CHAN_A = 1'b0;
    localparam logic CHAN_B = 1'b1;
    localparam logic STRAP_RST = 1'b1;

    typedef enum logic [1:0] {PM_ACTIVE, PM_PARTIAL, PM_FULL, PM_SAVE} duhp_pm_e;

    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} duhp_st_e;

    typedef struct packed {
        logic chan;
        logic [ADDR_W-1:0] addr;
    } duhp_acc_s;

endpackage

// file: core/duhp_edge.sv
// edge detector for one synchronous bus input
`timescale 1ns/1ps
module duhp_edge import duhp_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic sig,
    output logic fall,
    output logic rise
);
    logic prev;
    logic next_prev;

    always_comb begin
        next_prev = sig;
    end

    // idle level of every strobe and select is high
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            prev <= 1'b1;
        end else begin
            prev <= next_prev;
        end
    end

    assign fall = prev & ~sig;
    assign rise = ~prev & sig;
endmodule

// file: core/duhp_regfile.sv
// byte register store for both channels with registered read
`timescale 1ns/1ps
module duhp_regfile import duhp_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic wr_en,
    input duhp_acc_s wr_sel,
    input wire logic [DATA_W-1:0] wr_data,
    input duhp_acc_s rd_sel,
    output logic [DATA_W-1:0] rd_data,
    output logic [NUM_CHAN-1:0] oe_bits
);
    logic [DATA_W-1:0] mem [NUM_CHAN*NUM_REGS];
    logic [DATA_W-1:0] next_mem [NUM_CHAN*NUM_REGS];
    logic [DATA_W-1:0] next_rd_data;

    always_comb begin
        next_mem = mem;
        if (wr_en) begin
            next_mem[wr_sel] = wr_data;
        end
        next_rd_data = mem[rd_sel];
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_CHAN*NUM_REGS; i++) begin
                mem[i] <= REG_RST;
            end
            rd_data <= REG_RST;
        end else begin
            mem <= next_mem;
            rd_data <= next_rd_data;
        end
    end

    assign oe_bits[0] = mem[{CHAN_A, MCR_IDX}][MCR_OE_BIT];
    assign oe_bits[1] = mem[{CHAN_B, MCR_IDX}][MCR_OE_BIT];
endmodule

// file: core/duhp_port.sv
// host bus port: strobe decode, register access, interrupts, power modes
`timescale 1ns/1ps
module duhp_port import duhp_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic bus_style_sep,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic chan_a_select_n,
    input wire logic chan_b_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe_n,
    input wire logic [NUM_CHAN-1:0] chan_irq_req,
    input wire logic hw_osc_off,
    input wire logic hw_pump_off,
    input wire logic hw_power_save,
    input wire logic rx_activity,
    output logic chan_a_irq,
    output logic chan_a_irq_oe_n,
    output logic chan_b_irq,
    output logic chan_b_irq_oe_n,
    output logic osc_stop,
    output logic pump_stop,
    output logic rx_enable,
    output duhp_pm_e power_mode,
    output logic wake_flag
);
    logic rd_fall;
    logic rd_rise;
    logic wr_fall;
    logic wr_rise;
    logic csa_fall;
    logic csa_rise;

    duhp_edge u_rd_edge (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .sig(read_strobe_n),
        .fall(rd_fall),
        .rise(rd_rise)
    );

    duhp_edge u_wr_edge (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .sig(write_strobe_n),
        .fall(wr_fall),
        .rise(wr_rise)
    );

    duhp_edge u_csa_edge (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .sig(chan_a_select_n),
        .fall(csa_fall),
        .rise(csa_rise)
    );

    // bus style strap, caught once just after reset release
    logic sep_mode;
    logic strap_done;
    logic next_sep_mode;
    logic next_strap_done;

    always_comb begin
        next_sep_mode = strap_done ? sep_mode : bus_style_sep;
        next_strap_done = 1'b1;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sep_mode <= STRAP_RST;
            strap_done <= 1'b0;
        end else begin
            sep_mode <= next_sep_mode;
            strap_done <= next_strap_done;
        end
    end

    // start and end of a host cycle in either bus style
    logic start_rd;
    logic start_wr;
    logic end_rd;
    logic end_wr;
    logic any_sel;
    duhp_acc_s start_acc;
    logic iso;

    assign iso = (power_mode == PM_SAVE);

    always_comb begin
        start_acc.addr = addr;
        if (sep_mode) begin
            any_sel = ~chan_a_select_n | ~chan_b_select_n;
            start_acc.chan = ~chan_a_select_n ? CHAN_A : CHAN_B;
            start_rd = rd_fall & any_sel;
            start_wr = wr_fall & any_sel & ~start_rd;
            end_rd = rd_rise;
            end_wr = wr_rise;
        end else begin
            // read strobe plays no part in this style
            any_sel = ~chan_a_select_n;
            start_acc.chan = chan_b_select_n;
            start_rd = csa_fall & write_strobe_n;
            start_wr = csa_fall & ~write_strobe_n;
            end_rd = csa_rise;
            end_wr = csa_rise;
        end
    end

    // access sequencer
    duhp_st_e state;
    duhp_st_e next_state;
    duhp_acc_s acc;
    duhp_acc_s next_acc;
    duhp_acc_s rd_sel;
    logic wr_en;
    logic [DATA_W-1:0] rd_data;
    logic [NUM_CHAN-1:0] oe_bits;

    always_comb begin
        next_state = state;
        next_acc = acc;
        wr_en = 1'b0;
        case (state)
            ST_IDLE: begin
                if (!iso && start_rd) begin
                    next_state = ST_READ;
                    next_acc = start_acc;
                end else if (!iso && start_wr) begin
                    next_state = ST_WRITE;
                    next_acc = start_acc;
                end
            end
            ST_READ: begin
                if (iso || end_rd) begin
                    next_state = ST_IDLE;
                end
            end
            ST_WRITE: begin
                // data taken on the closing edge, so a slow host may set it late
                if (iso) begin
                    next_state = ST_IDLE;
                end else if (end_wr) begin
                    next_state = ST_IDLE;
                    wr_en = 1'b1;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        // read address leads by one cycle so the byte is ready on entry
        rd_sel = (state == ST_IDLE) ? start_acc : acc;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            acc <= '0;
        end else begin
            state <= next_state;
            acc <= next_acc;
        end
    end

    duhp_regfile u_regs (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wr_en(wr_en),
        .wr_sel(acc),
        .wr_data(data_in),
        .rd_sel(rd_sel),
        .rd_data(rd_data),
        .oe_bits(oe_bits)
    );

    // data bus drive
    logic [DATA_W-1:0] next_data_out;
    logic next_data_oe_n;
    logic rd_hold;

    always_comb begin
        rd_hold = (state == ST_READ) && (next_state == ST_READ);
        next_data_out = rd_hold ? rd_data : DOUT_RST;
        next_data_oe_n = ~rd_hold;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            data_out <= DOUT_RST;
            data_oe_n <= 1'b1;
        end else begin
            data_out <= next_data_out;
            data_oe_n <= next_data_oe_n;
        end
    end

    // power modes; serial activity clears the software sleep bits
    logic sw_osc;
    logic sw_pump;
    logic sw_save;
    logic next_sw_osc;
    logic next_sw_pump;
    logic next_sw_save;
    logic osc_req;
    logic pump_req;
    logic iso_req;
    logic pwr_wr;
    logic wake_clr;
    logic next_osc_stop;
    logic next_pump_stop;
    logic next_wake_flag;
    duhp_pm_e next_power_mode;

    always_comb begin
        pwr_wr = wr_en && (acc.chan == CHAN_A) && (acc.addr == PWR_IDX);
        next_sw_osc = sw_osc;
        next_sw_pump = sw_pump;
        next_sw_save = sw_save;
        if (pwr_wr) begin
            next_sw_osc = data_in[PWR_OSC_BIT];
            next_sw_pump = data_in[PWR_PUMP_BIT];
            next_sw_save = data_in[PWR_SAVE_BIT];
        end
        if (rx_activity) begin
            next_sw_osc = 1'b0;
            next_sw_pump = 1'b0;
            next_sw_save = 1'b0;
        end
        osc_req = hw_osc_off | sw_osc;
        pump_req = hw_pump_off | sw_pump;
        iso_req = (osc_req | pump_req) & (hw_power_save | sw_save);
        if (iso_req) begin
            next_power_mode = PM_SAVE;
        end else if (osc_req && pump_req) begin
            next_power_mode = PM_FULL;
        end else if (osc_req || pump_req) begin
            next_power_mode = PM_PARTIAL;
        end else begin
            next_power_mode = PM_ACTIVE;
        end
        next_osc_stop = osc_req;
        next_pump_stop = pump_req;
        // a wake-up event in the same cycle as the clearing read is kept
        wake_clr = (state == ST_IDLE) && !iso && start_rd && (start_acc.addr == IIR_IDX);
        next_wake_flag = ((osc_stop | pump_stop) & ~(osc_req | pump_req))
                         | (wake_flag & ~wake_clr);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sw_osc <= 1'b0;
            sw_pump <= 1'b0;
            sw_save <= 1'b0;
            osc_stop <= 1'b0;
            pump_stop <= 1'b0;
            power_mode <= PM_ACTIVE;
            rx_enable <= 1'b1;
            wake_flag <= 1'b0;
        end else begin
            sw_osc <= next_sw_osc;
            sw_pump <= next_sw_pump;
            sw_save <= next_sw_save;
            osc_stop <= next_osc_stop;
            pump_stop <= next_pump_stop;
            power_mode <= next_power_mode;
            rx_enable <= 1'b1;
            wake_flag <= next_wake_flag;
        end
    end

    // interrupt pins; shared line ignores the enable bits and is driven low on any request
    logic next_a_irq;
    logic next_a_oe_n;
    logic next_b_irq;
    logic next_b_oe_n;
    logic shared_req;

    always_comb begin
        shared_req = (|chan_irq_req) | wake_flag;
        if (sep_mode) begin
            next_a_irq = chan_irq_req[0] | wake_flag;
            next_a_oe_n = ~oe_bits[0];
            next_b_irq = chan_irq_req[1] | wake_flag;
            next_b_oe_n = ~oe_bits[1];
        end else begin
            next_a_irq = 1'b0;
            next_a_oe_n = ~shared_req;
            next_b_irq = 1'b0;
            next_b_oe_n = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            chan_a_irq <= 1'b0;
            chan_a_irq_oe_n <= 1'b1;
            chan_b_irq <= 1'b0;
            chan_b_irq_oe_n <= 1'b1;
        end else begin
            chan_a_irq <= next_a_irq;
            chan_a_irq_oe_n <= next_a_oe_n;
            chan_b_irq <= next_b_irq;
            chan_b_irq_oe_n <= next_b_oe_n;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    a_addr_capture: assert property (
        (state == ST_IDLE && next_state != ST_IDLE) |=> acc.addr == $past(addr))
        else $error("access address not captured");

    a_read_drive: assert property (
        (state == ST_READ && next_state == ST_READ)
        |=> !data_oe_n && data_out == $past(rd_data))
        else $error("read byte not driven");

    a_bus_float: assert property (
        (state != ST_READ) |=> data_oe_n)
        else $error("data bus driven outside read");

    a_write_rise: assert property (
        (sep_mode && wr_en) |-> !$past(write_strobe_n) && write_strobe_n)
        else $error("write not on strobe rise");

    a_rd_ignored: assert property (
        (!sep_mode && state == ST_IDLE && !csa_fall) |=> state == ST_IDLE)
        else $error("read strobe acted in single-line style");

    a_sel_needed: assert property (
        (sep_mode && state == ST_IDLE && chan_a_select_n && chan_b_select_n)
        |=> state == ST_IDLE)
        else $error("cycle started without select");

    a_chan_bit: assert property (
        (!sep_mode && state == ST_IDLE && csa_fall && !iso)
        |=> acc.chan == $past(chan_b_select_n))
        else $error("channel bit not used");

    a_irq_enable: assert property (
        (sep_mode && strap_done) |=> chan_b_irq_oe_n == !$past(oe_bits[1])
        && chan_a_irq_oe_n == !$past(oe_bits[0]))
        else $error("interrupt enable not followed");

    a_shared_irq: assert property (
        (!sep_mode && strap_done) |=> !chan_a_irq && chan_b_irq_oe_n
        && chan_a_irq_oe_n == !$past(shared_req))
        else $error("shared interrupt wrong");

    a_iso_bus: assert property (
        (power_mode == PM_SAVE) |=> state == ST_IDLE)
        else $error("bus not isolated in power-save");

    a_full_sleep: assert property (
        (osc_req && pump_req) |=> osc_stop && pump_stop
        && (power_mode == PM_FULL || power_mode == PM_SAVE))
        else $error("full sleep not entered");

    a_wake_set: assert property (
        ((osc_stop || pump_stop) && !osc_req && !pump_req) |=> wake_flag && power_mode == PM_ACTIVE)
        else $error("wake-up interrupt missing");

    a_rx_alive: assert property (
        strap_done |-> rx_enable)
        else $error("receivers disabled");
endmodule

// file: testbench/duhp_host.sv
// host processor model on the parallel bus of the port
`timescale 1ns/1ps
module duhp_host import duhp_pkg::*; (
    input wire logic clk_sys,
    input wire logic style,
    input wire logic noisy,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic data_oe_n,
    output logic [ADDR_W-1:0] addr,
    output logic chan_a_select_n,
    output logic chan_b_select_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic [DATA_W-1:0] data_in
);
    logic [DATA_W-1:0] host_d;
    // resolved data wire: the device wins while its enable is low
    assign data_in = (data_oe_n === 1'b0) ? data_out : host_d;
    initial begin
        addr = 3'h0;
        chan_a_select_n = 1'b1;
        chan_b_select_n = 1'b1;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        host_d = 8'h00;
    end
    task automatic acc(input logic wr, input logic ch, input logic en,
            input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
            output logic [DATA_W-1:0] q, output logic got);
        got = 1'b0;
        q = 8'h00;
        @(posedge clk_sys);
        #1;
        addr = a;
        if (wr) host_d = d;
        if (style) begin
            chan_a_select_n = !(en && ch == CHAN_A);
            chan_b_select_n = !(en && ch == CHAN_B);
            read_strobe_n = wr;
            write_strobe_n = !wr;
        end else begin
            chan_b_select_n = ch;
            write_strobe_n = !wr;
            read_strobe_n = !noisy;
            chan_a_select_n = !en;
        end
        // a read holds until the data enable is sampled low, bounded
        // looked at just after the edge, once the registered enable has settled
        for (int n = 0; n < (wr ? 3 : 6) && !got; n++) begin
            @(posedge clk_sys);
            #1;
            if (!wr && data_oe_n === 1'b0) begin
                got = 1'b1;
                q = data_out;
            end
        end
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        chan_a_select_n = 1'b1;
        chan_b_select_n = 1'b1;
        // data stays through the edge that samples the rise
        @(posedge clk_sys);
        #1;
        host_d = ~host_d;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
endmodule

// file: testbench/duhp_port_tb.sv
// self-checking bench for the dual channel host bus port
`timescale 1ns/1ps
module duhp_port_tb import duhp_pkg::*;;
    typedef struct packed {logic ch; logic [2:0] a; logic [7:0] d;} duhp_row_s;
    duhp_row_s rows [6] = '{'{CHAN_A, 3'h0, 8'hA5}, '{CHAN_B, 3'h0, 8'h5A},
        '{CHAN_A, 3'h5, 8'h3C}, '{CHAN_B, 3'h6, 8'hC3}, '{CHAN_A, 3'h1, 8'hFF},
        '{CHAN_B, 3'h7, 8'h80}};
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic bus_style_sep = STRAP_RST;
    logic noisy = 1'b0;
    logic [NUM_CHAN-1:0] chan_irq_req = 2'h0;
    logic hw_osc_off = 1'b0;
    logic hw_pump_off = 1'b0;
    logic hw_power_save = 1'b0;
    logic rx_activity = 1'b0;
    logic [ADDR_W-1:0] addr;
    logic chan_a_select_n, chan_b_select_n, read_strobe_n, write_strobe_n;
    logic [DATA_W-1:0] data_in, data_out, q;
    logic data_oe_n, chan_a_irq, chan_a_irq_oe_n, chan_b_irq, chan_b_irq_oe_n;
    logic osc_stop, pump_stop, rx_enable, wake_flag, got;
    duhp_pm_e power_mode;
    int errors = 0;
    int checks_done = 0;
    // shared request line with its pull-up
    wire irq_line = chan_a_irq_oe_n ? 1'b1 : chan_a_irq;
    duhp_port i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .bus_style_sep(bus_style_sep),
        .addr(addr), .chan_a_select_n(chan_a_select_n), .chan_b_select_n(chan_b_select_n),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .data_in(data_in),
        .data_out(data_out), .data_oe_n(data_oe_n), .chan_irq_req(chan_irq_req),
        .hw_osc_off(hw_osc_off), .hw_pump_off(hw_pump_off), .hw_power_save(hw_power_save),
        .rx_activity(rx_activity), .chan_a_irq(chan_a_irq), .chan_a_irq_oe_n(chan_a_irq_oe_n),
        .chan_b_irq(chan_b_irq), .chan_b_irq_oe_n(chan_b_irq_oe_n), .osc_stop(osc_stop),
        .pump_stop(pump_stop), .rx_enable(rx_enable), .power_mode(power_mode),
        .wake_flag(wake_flag));
    duhp_host i_host (.clk_sys(clk_sys), .style(bus_style_sep), .noisy(noisy),
        .data_out(data_out), .data_oe_n(data_oe_n), .addr(addr),
        .chan_a_select_n(chan_a_select_n), .chan_b_select_n(chan_b_select_n),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .data_in(data_in));
    initial forever #20 clk_sys = ~clk_sys;
    task automatic wrap_up;
        if (errors == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk_b(input logic [7:0] g, input logic [7:0] e, input string m);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t ns: %s got %h want %h", $time, m, g, e);
        end
    endtask
    task automatic chk_f(input logic g, input logic e, input string m);
        chk_b({7'h00, g}, {7'h00, e}, m);
    endtask
    task automatic chk_m(input duhp_pm_e g, input duhp_pm_e e, input string m);
        chk_b({6'h00, g}, {6'h00, e}, m);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic ch, input logic en, input logic [2:0] a,
            input logic [7:0] d);
        i_host.acc(1'b1, ch, en, a, d, q, got);
    endtask
    task automatic rd(input logic ch, input logic en, input logic [2:0] a,
            input logic ans, input logic [7:0] e);
        i_host.acc(1'b0, ch, en, a, 8'h00, q, got);
        chk_f(got, ans, "answer");
        if (got === 1'b1) chk_b(q, e, "read data");
        // an expected answer that never came ends the run
        if (ans && got !== 1'b1) wrap_up;
    endtask
    task automatic do_reset(input logic s);
        @(posedge clk_sys);
        #1;
        rst_n = 1'b0;
        bus_style_sep = s;
        cyc(2);
        rst_n = 1'b1;
        cyc(2);
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        wrap_up;
    end
    initial begin
        do_reset(1'b1);
        chk_b({data_oe_n, chan_a_irq_oe_n, chan_b_irq_oe_n, osc_stop, pump_stop,
            rx_enable, wake_flag, chan_a_irq}, 8'hE4, "reset outs");
        chk_m(power_mode, PM_ACTIVE, "reset mode");
        foreach (rows[i]) wr(rows[i].ch, 1'b1, rows[i].a, rows[i].d);
        foreach (rows[i]) rd(rows[i].ch, 1'b1, rows[i].a, 1'b1, rows[i].d);
        wr(CHAN_A, 1'b0, 3'h0, 8'h11);
        rd(CHAN_A, 1'b0, 3'h0, 1'b0, 8'h00);
        rd(CHAN_A, 1'b1, 3'h0, 1'b1, 8'hA5);
        chan_irq_req = 2'b01;
        cyc(2);
        chk_f(chan_a_irq_oe_n, 1'b1, "irq a float");
        wr(CHAN_A, 1'b1, MCR_IDX, 8'h08);
        cyc(2);
        chk_b({5'h00, chan_a_irq, chan_a_irq_oe_n, chan_b_irq_oe_n}, 8'h05, "irq a");
        chan_irq_req = 2'b10;
        wr(CHAN_B, 1'b1, MCR_IDX, 8'h08);
        cyc(2);
        chk_b({5'h00, chan_b_irq, chan_b_irq_oe_n, chan_a_irq}, 8'h04, "irq b");
        chan_irq_req = 2'b00;
        hw_pump_off = 1'b1;
        cyc(3);
        chk_m(power_mode, PM_PARTIAL, "hw partial");
        chk_b({6'h00, osc_stop, pump_stop}, 8'h01, "pump stop");
        hw_osc_off = 1'b1;
        hw_power_save = 1'b1;
        cyc(3);
        chk_m(power_mode, PM_SAVE, "hw save");
        chk_b({5'h00, osc_stop, pump_stop, rx_enable}, 8'h07, "full stop");
        rd(CHAN_B, 1'b1, 3'h0, 1'b0, 8'h00);
        hw_osc_off = 1'b0;
        hw_pump_off = 1'b0;
        hw_power_save = 1'b0;
        cyc(3);
        chk_m(power_mode, PM_ACTIVE, "hw awake");
        chk_f(wake_flag, 1'b1, "hw wake");
        i_host.acc(1'b0, CHAN_A, 1'b1, IIR_IDX, 8'h00, q, got);
        chk_f(wake_flag, 1'b0, "wake cleared");
        wr(CHAN_A, 1'b1, PWR_IDX, 8'h03);
        cyc(2);
        chk_m(power_mode, PM_FULL, "sw full");
        wr(CHAN_A, 1'b1, PWR_IDX, 8'h07);
        cyc(2);
        chk_m(power_mode, PM_SAVE, "sw save");
        wr(CHAN_B, 1'b1, 3'h0, 8'hEE);
        rx_activity = 1'b1;
        cyc(1);
        rx_activity = 1'b0;
        cyc(3);
        chk_m(power_mode, PM_ACTIVE, "rx awake");
        chk_f(wake_flag, 1'b1, "rx wake");
        rd(CHAN_B, 1'b1, 3'h0, 1'b1, 8'h5A);
        do_reset(1'b0);
        noisy = 1'b1;
        wr(CHAN_B, 1'b1, 3'h5, 8'h77);
        wr(CHAN_A, 1'b1, 3'h5, 8'h66);
        rd(CHAN_B, 1'b1, 3'h5, 1'b1, 8'h77);
        rd(CHAN_A, 1'b1, 3'h5, 1'b1, 8'h66);
        rd(CHAN_A, 1'b0, 3'h5, 1'b0, 8'h00);
        chan_irq_req = 2'b10;
        cyc(2);
        chk_b({5'h00, irq_line, chan_a_irq_oe_n, chan_b_irq_oe_n}, 8'h01, "shared irq");
        chan_irq_req = 2'b00;
        cyc(2);
        chk_f(irq_line, 1'b1, "shared idle");
        wrap_up;
    end
endmodule
